// ==== core/csc_defines.svh ====
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CSC_MISC_OFS 4'h0
`define CSC_DIG_OFS 4'h4
`define CSC_STAT_OFS 4'h8

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CSC_MISC_TIMER_BIT 0
`define CSC_MISC_MODE_BIT 1
`define CSC_DIG_ALL_BIT 0
`define CSC_DIG_ST0_BIT 7
`define CSC_DIG_ST1_BIT 8
`define CSC_DIG_FREQ_LSB 9
`define CSC_DIG_FREQ_MSB 20
`define CSC_DIG_XSW_BIT 21
`define CSC_DIG_DUAL_BIT 22
`define CSC_DIG_SIG_BIT 23
`define CSC_DIG_WMASK 32'h00ffff81
`define CSC_STAT_FAIL_BIT 0
`define CSC_STAT_RELOAD_BIT 1
`define CSC_STAT_BUSY_BIT 2
`define CSC_STAT_DONE_BIT 3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CSC_MISC_RST 2'h0
`define CSC_DIG_RST 32'h00000000

// ------------------------------------------------------------
// self test order and timing
// ------------------------------------------------------------
`define CSC_T_SIG 3'h0
`define CSC_T_DUAL 3'h1
`define CSC_T_XSW 3'h2
`define CSC_T_FREQ 3'h3
`define CSC_T_ST1 3'h4
`define CSC_T_ST0 3'h5
`define CSC_T_LAST 3'h5
`define CSC_CLK_HZ 20000000
`define CSC_SIG_INTERVAL_MS 10
`define CSC_SIG_INTERVAL_CYC ((`CSC_SIG_INTERVAL_MS * `CSC_CLK_HZ) / 1000)

`endif

// ==== core/csc_pkg.sv ====
package csc_pkg;
   // self test sequencer, gray along idle-pick-wait-done
   typedef enum logic [2:0] {
      CSC_ST_IDLE = 3'b000,
      CSC_ST_PICK = 3'b001,
      CSC_ST_WAIT = 3'b011,
      CSC_ST_DONE = 3'b010
   } csc_st_t;
   // reload sequence
   typedef enum logic [1:0] {
      CSC_RL_IDLE = 2'b00,
      CSC_RL_LOAD = 2'b01,
      CSC_RL_BOOT = 2'b11
   } csc_rl_t;
   // action taken on signature mismatch
   typedef enum logic {
      CSC_ERR_FLAG = 1'b0,
      CSC_ERR_RELOAD = 1'b1
   } csc_err_t;
endpackage

// ==== core/csc_tick.sv ====
`timescale 1ns/100ps
// one-cycle pulse every PERIOD cycles while enabled
module csc_tick #(
   parameter int unsigned PERIOD = 200000
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_en,
   // pulse
   output logic o_tick
);
   logic [31:0] cnt_q;

   // restart on disable so the first check comes a full period later
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !i_en) begin
         cnt_q <= 32'h0;
         o_tick <= 1'b0;
      end else if (cnt_q == PERIOD - 1) begin
         cnt_q <= 32'h0;
         o_tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         o_tick <= 1'b0;
      end
   end
endmodule

// ==== core/csc_ctrl.sv ====
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "csc_defines.svh"
// signature check and startup self test control
module csc_ctrl #(
   parameter int unsigned SIG_PERIOD = `CSC_SIG_INTERVAL_CYC,
   parameter int unsigned N_OUT = 12
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // avalon-mm slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // configuration signature
   input wire logic [31:0] i_sig_calc,
   input wire logic [31:0] i_sig_ref,
   // reload and power-up sequence
   output logic o_outputs_disable,
   output logic o_otp_reload_req,
   input wire logic i_otp_reload_done,
   output logic o_powerup_restart,
   input wire logic i_powerup_done,
   // output rate monitor selects
   input wire logic [N_OUT-1:0] i_freq_sel_true,
   input wire logic [N_OUT-1:0] i_freq_sel_comp,
   // self test engines
   input wire logic i_selftest_start,
   output logic [5:0] o_test_start,
   input wire logic [5:0] i_test_done,
   output logic [N_OUT-1:0] o_freq_test_mask,
   output logic o_selftest_busy
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [1:0] misc_q;
   logic [31:0] dig_q;
   logic fail_q;
   logic reload_q;
   logic done_q;
   logic ack_q;
   logic req;
   logic wr_en;
   logic rd_en;
   logic tick;
   logic chk_event;
   logic mismatch;
   logic sel_any;
   logic [2:0] idx_q;
   logic clr_fail;
   logic clr_reload;
   logic clr_done;
   csc_pkg::csc_st_t st_q;
   csc_pkg::csc_rl_t rl_q;
   csc_pkg::csc_err_t err_mode;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // whether a test runs, given the disable register
   function automatic logic test_en(input logic [2:0] t, input logic [31:0] d,
                                    input logic any);
      logic r;
      r = 1'b0;
      case (t)
         `CSC_T_SIG: r = !d[`CSC_DIG_SIG_BIT];
         `CSC_T_DUAL: r = !d[`CSC_DIG_DUAL_BIT];
         `CSC_T_XSW: r = !d[`CSC_DIG_XSW_BIT];
         `CSC_T_FREQ: r = any && (~d[`CSC_DIG_FREQ_MSB:`CSC_DIG_FREQ_LSB] != '0);
         `CSC_T_ST1: r = !d[`CSC_DIG_ST1_BIT];
         `CSC_T_ST0: r = !d[`CSC_DIG_ST0_BIT];
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   // one wait cycle per access; the write lands on the released edge
   assign req = i_avs_read || i_avs_write;
   assign o_avs_waitrequest = req && !ack_q;
   assign wr_en = i_avs_write && ack_q;
   assign rd_en = i_avs_read && !ack_q;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req && !ack_q;
      end
   end

   // read data captured one cycle ahead; unmapped reads give zero
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_avs_readdata <= 32'h0;
      end else if (rd_en) begin
         if (i_avs_address == `CSC_MISC_OFS) begin
            o_avs_readdata <= {30'h0, misc_q};
         end else if (i_avs_address == `CSC_DIG_OFS) begin
            o_avs_readdata <= dig_q & `CSC_DIG_WMASK;
         end else if (i_avs_address == `CSC_STAT_OFS) begin
            o_avs_readdata <= {28'h0, done_q, o_selftest_busy, reload_q, fail_q};
         end else begin
            o_avs_readdata <= 32'h0;
         end
      end
   end

   // configuration registers
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         misc_q <= `CSC_MISC_RST;
         dig_q <= `CSC_DIG_RST;
      end else if (wr_en) begin
         if (i_avs_address == `CSC_MISC_OFS) begin
            misc_q <= i_avs_writedata[1:0];
         end else if (i_avs_address == `CSC_DIG_OFS) begin
            dig_q <= i_avs_writedata & `CSC_DIG_WMASK;
         end
      end
   end

   // write-one-to-clear strobes for the status flags
   assign clr_fail = wr_en && (i_avs_address == `CSC_STAT_OFS)
                     && i_avs_writedata[`CSC_STAT_FAIL_BIT];
   assign clr_reload = wr_en && (i_avs_address == `CSC_STAT_OFS)
                       && i_avs_writedata[`CSC_STAT_RELOAD_BIT];
   assign clr_done = wr_en && (i_avs_address == `CSC_STAT_OFS)
                     && i_avs_writedata[`CSC_STAT_DONE_BIT];

   // ------------------------------------------------------------
   // periodic signature check
   // ------------------------------------------------------------
   csc_tick #(
      .PERIOD(SIG_PERIOD)
   ) u_tick (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_en(misc_q[`CSC_MISC_TIMER_BIT]),
      .o_tick(tick)
   );

   assign err_mode = csc_pkg::csc_err_t'(misc_q[`CSC_MISC_MODE_BIT]);
   assign mismatch = i_sig_calc != i_sig_ref;
   // checks held while a reload runs, the signature is in flux then
   assign chk_event = tick && misc_q[`CSC_MISC_TIMER_BIT]
                      && (rl_q == csc_pkg::CSC_RL_IDLE);

   // failure flag, set wins over clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         fail_q <= 1'b0;
      end else if (chk_event && mismatch && err_mode == csc_pkg::CSC_ERR_FLAG) begin
         fail_q <= 1'b1;
      end else if (clr_fail) begin
         fail_q <= 1'b0;
      end
   end

   // reload flag, set wins over clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         reload_q <= 1'b0;
      end else if (chk_event && mismatch && err_mode == csc_pkg::CSC_ERR_RELOAD) begin
         reload_q <= 1'b1;
      end else if (clr_reload) begin
         reload_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // reload sequence
   // ------------------------------------------------------------
   // outputs stay off until the power-up sequence reports done
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rl_q <= csc_pkg::CSC_RL_IDLE;
         o_outputs_disable <= 1'b0;
         o_otp_reload_req <= 1'b0;
         o_powerup_restart <= 1'b0;
      end else begin
         o_powerup_restart <= 1'b0;
         case (rl_q)
            csc_pkg::CSC_RL_IDLE: begin
               if (chk_event && mismatch && err_mode == csc_pkg::CSC_ERR_RELOAD) begin
                  rl_q <= csc_pkg::CSC_RL_LOAD;
                  o_outputs_disable <= 1'b1;
                  o_otp_reload_req <= 1'b1;
               end
            end
            csc_pkg::CSC_RL_LOAD: begin
               if (i_otp_reload_done) begin
                  rl_q <= csc_pkg::CSC_RL_BOOT;
                  o_otp_reload_req <= 1'b0;
                  o_powerup_restart <= 1'b1;
               end
            end
            csc_pkg::CSC_RL_BOOT: begin
               if (i_powerup_done) begin
                  rl_q <= csc_pkg::CSC_RL_IDLE;
                  o_outputs_disable <= 1'b0;
               end
            end
            default: begin
               rl_q <= csc_pkg::CSC_RL_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // startup self test sequencer
   // ------------------------------------------------------------
   assign sel_any = (i_freq_sel_true != '0) || (i_freq_sel_comp != '0);
   assign o_selftest_busy = st_q != csc_pkg::CSC_ST_IDLE;

   // one test at a time, in fixed order; disabled ones are passed over
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_q <= csc_pkg::CSC_ST_IDLE;
         idx_q <= 3'h0;
         o_test_start <= 6'h0;
         o_freq_test_mask <= '0;
      end else begin
         o_test_start <= 6'h0;
         case (st_q)
            csc_pkg::CSC_ST_IDLE: begin
               idx_q <= 3'h0;
               if (i_selftest_start) begin
                  if (dig_q[`CSC_DIG_ALL_BIT]) begin
                     st_q <= csc_pkg::CSC_ST_DONE;
                  end else begin
                     st_q <= csc_pkg::CSC_ST_PICK;
                  end
               end
            end
            csc_pkg::CSC_ST_PICK: begin
               if (test_en(idx_q, dig_q, sel_any)) begin
                  o_test_start[idx_q] <= 1'b1;
                  st_q <= csc_pkg::CSC_ST_WAIT;
                  if (idx_q == `CSC_T_FREQ) begin
                     o_freq_test_mask <= ~dig_q[`CSC_DIG_FREQ_MSB:`CSC_DIG_FREQ_LSB];
                  end
               end else if (idx_q == `CSC_T_LAST) begin
                  st_q <= csc_pkg::CSC_ST_DONE;
               end else begin
                  idx_q <= idx_q + 3'h1;
               end
            end
            csc_pkg::CSC_ST_WAIT: begin
               if (i_test_done[idx_q]) begin
                  o_freq_test_mask <= '0;
                  if (idx_q == `CSC_T_LAST) begin
                     st_q <= csc_pkg::CSC_ST_DONE;
                  end else begin
                     idx_q <= idx_q + 3'h1;
                     st_q <= csc_pkg::CSC_ST_PICK;
                  end
               end
            end
            csc_pkg::CSC_ST_DONE: begin
               st_q <= csc_pkg::CSC_ST_IDLE;
            end
            default: begin
               st_q <= csc_pkg::CSC_ST_IDLE;
            end
         endcase
      end
   end

   // sequence done flag, set wins over clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         done_q <= 1'b0;
      end else if (st_q == csc_pkg::CSC_ST_DONE) begin
         done_q <= 1'b1;
      end else if (clr_done) begin
         done_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   chk_fail_flag: assert property (
      chk_event && mismatch && !misc_q[1] |=> fail_q && !o_outputs_disable)
      else $error("failure flag not set on mismatch");
   chk_reload_seq: assert property (
      chk_event && mismatch && misc_q[1] |=> reload_q && o_outputs_disable
      && o_otp_reload_req && !$rose(fail_q))
      else $error("reload sequence not started");
   chk_restart_pulse: assert property (
      rl_q == csc_pkg::CSC_RL_LOAD && i_otp_reload_done |=> o_powerup_restart
      ##1 !o_powerup_restart && o_outputs_disable)
      else $error("power-up restart missing");
   chk_timer_off: assert property (
      !misc_q[0] && !$past(misc_q[0]) |-> !tick)
      else $error("check ran with timer off");
   chk_tick_space: assert property (
      chk_event |=> !chk_event [*8])
      else $error("checks too close");
   chk_sig_skip: assert property (
      st_q == csc_pkg::CSC_ST_PICK && dig_q[23] |=> !o_test_start[0])
      else $error("signature test ran while disabled");
   chk_dual_skip: assert property (
      st_q == csc_pkg::CSC_ST_PICK && dig_q[22] |=> !o_test_start[1])
      else $error("dual crystal test ran while disabled");
   chk_xsw_skip: assert property (
      st_q == csc_pkg::CSC_ST_PICK && dig_q[21] |=> !o_test_start[2])
      else $error("switchover test ran while disabled");
   chk_freq_mask: assert property (
      o_test_start[3] |-> o_freq_test_mask == ~$past(dig_q[20:9]))
      else $error("rate test mask wrong");
   chk_freq_auto: assert property (
      st_q == csc_pkg::CSC_ST_PICK && idx_q == 3'h3 && !sel_any |=> !o_test_start[3])
      else $error("rate test ran with no selects");
   chk_st_skip: assert property (
      st_q == csc_pkg::CSC_ST_PICK && dig_q[8] && dig_q[7] |=> o_test_start[5:4] == 2'h0)
      else $error("short-term test ran while disabled");
   chk_all_skip: assert property (
      st_q == csc_pkg::CSC_ST_IDLE && i_selftest_start && dig_q[0]
      |=> st_q == csc_pkg::CSC_ST_DONE && o_test_start == 6'h0)
      else $error("self test ran while all disabled");
   chk_rsvd_zero: assert property (
      dig_q[31:24] == 8'h0)
      else $error("reserved bits stored");

   cov_fail: cover property (chk_event && mismatch && !misc_q[1]);
   cov_reload: cover property (o_powerup_restart);
   cov_freq: cover property (o_test_start[3]);
   cov_done: cover property (st_q == csc_pkg::CSC_ST_DONE);
endmodule

// ==== testbench/tb_config_signature_and_selftest_control.sv ====
`timescale 1ns/100ps
`include "csc_defines.svh"
// one compare: counts it, reports a mismatch at once
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module tb_config_signature_and_selftest_control;
   // ------------------------------------------------------------
   // design signals
   // ------------------------------------------------------------
   logic i_clk, i_sys_rst, i_avs_read, i_avs_write;
   logic [3:0] i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, i_sig_calc, i_sig_ref;
   logic o_avs_waitrequest, o_outputs_disable, o_otp_reload_req, i_otp_reload_done;
   logic o_powerup_restart, i_powerup_done, i_selftest_start, o_selftest_busy;
   logic [11:0] i_freq_sel_true, i_freq_sel_comp, o_freq_test_mask;
   logic [5:0] o_test_start, i_test_done;
   int n_fail = 0;
   int n_checks = 0;
   int seed = 96;
   logic [31:0] v;

   // short signature period keeps each check under thirty cycles
   csc_ctrl #(.SIG_PERIOD(20), .N_OUT(12)) u_csc_ctrl (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_sig_calc(i_sig_calc), .i_sig_ref(i_sig_ref),
      .o_outputs_disable(o_outputs_disable), .o_otp_reload_req(o_otp_reload_req),
      .i_otp_reload_done(i_otp_reload_done), .o_powerup_restart(o_powerup_restart),
      .i_powerup_done(i_powerup_done), .i_freq_sel_true(i_freq_sel_true),
      .i_freq_sel_comp(i_freq_sel_comp), .i_selftest_start(i_selftest_start),
      .o_test_start(o_test_start), .i_test_done(i_test_done),
      .o_freq_test_mask(o_freq_test_mask), .o_selftest_busy(o_selftest_busy));

   // 20 MHz clock
   initial i_clk = 1'b0;
   always #25 i_clk = ~i_clk;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // avalon access: hold until waitrequest seen low, then one idle edge
   // a slave that never answers is left to the watchdog
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      @(posedge i_clk);
      while (o_avs_waitrequest !== 1'b0) begin
         @(posedge i_clk);
      end
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask

   // which engines should start for a given disable word and selects
   function automatic logic [5:0] exp_tests(logic [31:0] d, logic [11:0] st, logic [11:0] sc);
      logic [5:0] e;
      e = {!d[7], !d[8], (|(st | sc)) && (d[20:9] != 12'hfff), !d[21], !d[22], !d[23]};
      return d[0] ? 6'h00 : e;
   endfunction

   // run one self test sequence, engines answer after a random delay
   task automatic run_st(input logic [31:0] d, input logic [11:0] st, input logic [11:0] sc);
      logic [5:0] seen, pend, ex, dn;
      logic [11:0] fm;
      int n, dl;
      seen = 6'h00;
      pend = 6'h00;
      dn = 6'h00;
      fm = 12'h000;
      n = 0;
      dl = 0;
      // software skips the rate test of outputs without any monitor select
      if ((st | sc) != 12'h000) d[20:9] = d[20:9] | ~(st | sc);
      ex = exp_tests(d, st, sc);
      wr(4'h4, d);
      i_freq_sel_true <= st;
      i_freq_sel_comp <= sc;
      i_selftest_start <= 1'b1;
      @(posedge i_clk);
      i_selftest_start <= 1'b0;
      @(posedge i_clk);
      while (o_selftest_busy === 1'b1 && n < 300) begin
         dn = 6'h00;
         if (o_test_start !== 6'h00) begin
            seen = seen | o_test_start;
            pend = o_test_start;
            dl = $unsigned($random(seed)) % 4;
            if (o_test_start[3] === 1'b1) fm = o_freq_test_mask;
         end else if (pend != 6'h00 && dl == 0) begin
            dn = pend;
            pend = 6'h00;
         end else if (dl > 0) dl--;
         // one drive per edge, done is a single-cycle pulse
         i_test_done <= dn;
         @(posedge i_clk);
         n++;
      end
      i_test_done <= 6'h00;
      `CHK("busy ended", 1'b0, o_selftest_busy)
      `CHK("sig test", ex[0], seen[0])
      `CHK("dual test", ex[1], seen[1])
      `CHK("switch test", ex[2], seen[2])
      `CHK("rate test", ex[3], seen[3])
      `CHK("xtal1 st test", ex[4], seen[4])
      `CHK("xtal0 st test", ex[5], seen[5])
      if (ex[3]) `CHK("rate mask", ~d[20:9], fm)
      rd(4'h8, v);
      `CHK("seq done busy", 2'b10, v[3:2])
      wr(4'h8, 32'h8);
      @(posedge i_clk);
   endtask

   // ------------------------------------------------------------
   // watchdog, far beyond the expected thousand or so cycles
   // ------------------------------------------------------------
   initial begin
      #(50 * 40000);
      n_fail++;
      test_done();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   logic [31:0] cases [0:8] = '{32'h0, 32'h1, 32'h00800000, 32'h00400000, 32'h00200000,
      32'h00000100, 32'h00000080, 32'h001ffe00, 32'h00ffff80};
   initial begin
      {i_avs_read, i_avs_write, i_otp_reload_done, i_powerup_done, i_selftest_start} = 5'h00;
      i_avs_address = 4'h0;
      i_avs_writedata = 32'h0;
      i_sig_calc = 32'h0;
      i_sig_ref = 32'h0;
      i_freq_sel_true = 12'h000;
      i_freq_sel_comp = 12'h000;
      i_test_done = 6'h00;
      i_sys_rst = 1'b1;
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      // reset values and unmapped place
      for (int a = 0; a < 16; a += 4) begin
         rd(a[3:0], v);
         `CHK("reset read", 32'h0, v)
      end
      $display("test reset done");
      // reserved bits dropped, others stored
      for (int i = 0; i < 8; i++) begin
         logic [31:0] d;
         d = (i == 0) ? 32'hffffffff : $random(seed);
         wr(4'h4, d);
         rd(4'h4, v);
         `CHK("disable word", d & `CSC_DIG_WMASK, v)
      end
      $display("test disable register done");
      // flag mode: periodic check sets failure only
      i_sig_calc <= 32'h1234abcd;
      i_sig_ref <= 32'h1234abce;
      // fault enable for the failure flag lives outside this block
      wr(4'h0, 32'h1);
      repeat (8) @(posedge i_clk);
      rd(4'h8, v);
      `CHK("fail early", 1'b0, v[0])
      repeat (14) @(posedge i_clk);
      rd(4'h8, v);
      `CHK("fail flag", 2'b01, v[1:0])
      `CHK("outputs kept", 1'b0, o_outputs_disable)
      wr(4'h8, 32'hf);
      repeat (24) @(posedge i_clk);
      rd(4'h8, v);
      `CHK("fail again", 1'b1, v[0])
      // timer bit zero stops checking
      wr(4'h0, 32'h0);
      wr(4'h8, 32'hf);
      repeat (60) @(posedge i_clk);
      rd(4'h8, v);
      `CHK("timer off", 1'b0, v[0])
      $display("test flag mode done");
      // reload mode: disable outputs, reload, restart power-up
      // interrupt enable for the reload flag lives outside this block
      wr(4'h0, 32'h3);
      for (int n = 0; n < 40 && o_otp_reload_req !== 1'b1; n++) @(posedge i_clk);
      `CHK("reload req", 1'b1, o_otp_reload_req)
      `CHK("outputs off", 1'b1, o_outputs_disable)
      rd(4'h8, v);
      `CHK("reload flag", 2'b10, v[1:0])
      i_sig_calc <= 32'h1234abce;
      i_otp_reload_done <= 1'b1;
      @(posedge i_clk);
      i_otp_reload_done <= 1'b0;
      @(posedge i_clk);
      `CHK("restart pulse", 2'b10, {o_powerup_restart, o_otp_reload_req})
      @(posedge i_clk);
      `CHK("restart once", 1'b0, o_powerup_restart)
      repeat (5) @(posedge i_clk);
      `CHK("off until boot", 1'b1, o_outputs_disable)
      i_powerup_done <= 1'b1;
      @(posedge i_clk);
      i_powerup_done <= 1'b0;
      repeat (2) @(posedge i_clk);
      `CHK("outputs back", 1'b0, o_outputs_disable)
      wr(4'h0, 32'h0);
      $display("test reload mode done");
      // self test: corner disables, no selects, then random
      for (int i = 0; i < 20; i++) begin
         if (i < 9) run_st(cases[i], 12'h005, 12'ha00);
         else if (i == 9) run_st(32'h0, 12'h000, 12'h000);
         else run_st($random(seed) & 32'hfffffffe, $random(seed), $random(seed));
      end
      $display("test self test done");
      test_done();
   end
endmodule
